// ==== shared/cerr_pkg.sv ====
// Package for the cable echo result register bank.
// Assumes a single management clock and synchronous active-high reset.
package cerr_pkg;

    // ****************************************************************
    // Bus and register map
    // ****************************************************************
    localparam int unsigned CERR_ADDR_W = 11;
    localparam int unsigned CERR_DATA_W = 32;
    localparam int unsigned CERR_NUM_REGS = 7;
    localparam logic [8:0] CERR_IDX_LOC_D0_C4 = 9'h197;
    localparam logic [8:0] CERR_IDX_LOC_D2_D1 = 9'h198;
    localparam logic [8:0] CERR_IDX_LOC_D4_D3 = 9'h199;
    localparam logic [8:0] CERR_IDX_AMP_A1_A0 = 9'h19a;
    localparam logic [8:0] CERR_IDX_AMP_A3_A2 = 9'h19b;
    localparam logic [8:0] CERR_IDX_AMP_B0_A4 = 9'h19c;
    localparam logic [8:0] CERR_IDX_AMP_B2_B1 = 9'h19d;
    localparam logic [8:0] CERR_IDX_FIRST = CERR_IDX_LOC_D0_C4;
    // Own control/status register, outside the documented bank
    localparam logic [8:0] CERR_IDX_CTRL = 9'h1c0;
    localparam logic [15:0] CERR_REG_RESET = 16'h0000;
    localparam logic [31:0] CERR_UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [1:0] CERR_RESP_OK = 2'h0;
    localparam logic [1:0] CERR_RESP_DECERR = 2'h3;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int unsigned CERR_LOC_W = 8;
    localparam int unsigned CERR_AMP_W = 7;
    localparam int unsigned CERR_HI_LSB = 8;
    localparam int unsigned CERR_NUM_LOC = 6;
    localparam int unsigned CERR_NUM_AMP = 8;
    localparam int unsigned CERR_CTRL_HOLD_BIT = 0;
    localparam int unsigned CERR_STAT_VALID_BIT = 8;
    localparam int unsigned CERR_STAT_BLOCKED_BIT = 9;

    typedef logic [CERR_LOC_W-1:0] cerr_loc_t;
    typedef logic [CERR_AMP_W-1:0] cerr_amp_t;

    // Results delivered by the measurement engine, in register order
    typedef struct packed {
        cerr_loc_t [CERR_NUM_LOC-1:0] loc;
        cerr_amp_t [CERR_NUM_AMP-1:0] amp;
    } cerr_result_t;

    typedef struct packed {
        logic [CERR_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [CERR_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } cerr_av_req_t;

    typedef struct packed {
        logic [CERR_DATA_W-1:0] readdata;
        logic readdatavalid;
        logic waitrequest;
        logic [1:0] response;
    } cerr_av_rsp_t;

    typedef enum logic [1:0] {
        CERR_BUS_IDLE,
        CERR_BUS_ANSWER
    } cerr_bus_state_t;

endpackage : cerr_pkg

// ==== verilog/cerr_result_store.sv ====
// Result store: snapshot of all echo fields, loaded in one cycle.
// Assumes the load strobe comes from the owning bank.
`timescale 1ns/1ns
module cerr_result_store
    import cerr_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Load side
    input wire logic load_i,
    input wire cerr_result_t result_i,
    // Stored results
    output cerr_result_t stored_o,
    output logic valid_o
);

    typedef struct packed {
        cerr_result_t res;
        logic valid;
    } cerr_store_state_t;

    cerr_store_state_t state_q;
    cerr_store_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (load_i) begin
            state_d.res = result_i;
            state_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign stored_o = state_q.res;
    assign valid_o = state_q.valid;

endmodule : cerr_result_store

// ==== verilog/cerr_word_map.sv ====
// Word map: places stored fields into 16-bit result words.
// Assumes the stored fields are in register order.
`timescale 1ns/1ns
module cerr_word_map
    import cerr_pkg::*;
(
    // Stored fields
    input wire cerr_result_t stored_i,
    // Result words, index 0 at the first offset
    output logic [CERR_NUM_REGS-1:0][15:0] words_o
);

    // ****************************************************************
    // Location words: upper byte the later echo
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < CERR_NUM_LOC / 2; gi++) begin : g_loc
            assign words_o[gi] = {stored_i.loc[2*gi+1], stored_i.loc[2*gi]};
        end
        for (gi = 0; gi < CERR_NUM_AMP / 2; gi++) begin : g_amp
            // Reserved bits 15 and 7 fixed at zero
            assign words_o[CERR_NUM_LOC/2+gi] = {1'b0, stored_i.amp[2*gi+1],
                                                 1'b0, stored_i.amp[2*gi]};
        end
    endgenerate

endmodule : cerr_word_map

// ==== verilog/cerr_result_bank.sv ====
// Cable echo result register bank on an Avalon-MM slave.
// Assumes all inputs synchronous to clock_i; one read answer per request.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
module cerr_result_bank
    import cerr_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Avalon-MM slave, byte address
    input wire logic [CERR_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [CERR_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [CERR_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // Measurement engine
    input wire logic meas_done_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chc_fifth_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_first_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_second_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_third_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_fourth_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_fifth_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_first_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_second_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_third_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_fourth_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_fifth_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_chb_first_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_chb_second_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_chb_third_i,
    // Status
    output logic results_valid_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        cerr_bus_state_t bus;
        logic [CERR_DATA_W-1:0] rdata;
        logic [1:0] resp;
        logic hold;
        logic blocked;
    } cerr_bank_state_t;

    cerr_bank_state_t state_q;
    cerr_bank_state_t state_d;

    cerr_result_t result_in;
    cerr_result_t stored;
    cerr_av_req_t req;
    logic [CERR_NUM_REGS-1:0][15:0] words;
    logic load;
    logic store_valid;
    logic [8:0] idx;
    logic word_aligned;
    logic [8:0] rel;

    // ****************************************************************
    // Result capture
    // ****************************************************************
    always_comb begin
        result_in.loc[0] = echo_distance_chc_fifth_i;
        result_in.loc[1] = echo_distance_chd_first_i;
        result_in.loc[2] = echo_distance_chd_second_i;
        result_in.loc[3] = echo_distance_chd_third_i;
        result_in.loc[4] = echo_distance_chd_fourth_i;
        result_in.loc[5] = echo_distance_chd_fifth_i;
        result_in.amp[0] = echo_strength_cha_first_i;
        result_in.amp[1] = echo_strength_cha_second_i;
        result_in.amp[2] = echo_strength_cha_third_i;
        result_in.amp[3] = echo_strength_cha_fourth_i;
        result_in.amp[4] = echo_strength_cha_fifth_i;
        result_in.amp[5] = echo_strength_chb_first_i;
        result_in.amp[6] = echo_strength_chb_second_i;
        result_in.amp[7] = echo_strength_chb_third_i;
    end

    // Whole set loads at once unless software freezes it
    assign load = meas_done_i && !state_q.hold;

    cerr_result_store u_store (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .load_i(load),
        .result_i(result_in),
        .stored_o(stored),
        .valid_o(store_valid)
    );

    cerr_word_map u_map (
        .stored_i(stored),
        .words_o(words)
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    always_comb begin
        req.address = avs_address_i;
        req.read = avs_read_i;
        req.write = avs_write_i;
        req.writedata = avs_writedata_i;
        req.byteenable = avs_byteenable_i;
    end

    assign idx = req.address[CERR_ADDR_W-1:2];
    assign word_aligned = (req.address[1:0] == 2'h0);
    assign rel = idx - CERR_IDX_FIRST;

    always_comb begin
        state_d = state_q;
        case (state_q.bus)
            CERR_BUS_IDLE: begin
                if (req.read || req.write) begin
                    state_d.bus = CERR_BUS_ANSWER;
                    state_d.rdata = CERR_UNMAPPED_DATA;
                    state_d.resp = CERR_RESP_OK;
                    if (!word_aligned) begin
                        state_d.resp = CERR_RESP_DECERR;
                    end else if (idx >= CERR_IDX_FIRST &&
                                 idx < CERR_IDX_FIRST + 9'(CERR_NUM_REGS)) begin
                        // Result words are read-only; writes are dropped
                        if (req.read) begin
                            state_d.rdata = {16'h0000, words[rel[2:0]]};
                        end
                    end else if (idx == CERR_IDX_CTRL) begin
                        if (req.read) begin
                            state_d.rdata[CERR_CTRL_HOLD_BIT] = state_q.hold;
                            state_d.rdata[CERR_STAT_VALID_BIT] = store_valid;
                            state_d.rdata[CERR_STAT_BLOCKED_BIT] = state_q.blocked;
                        end
                    end else begin
                        state_d.resp = CERR_RESP_DECERR;
                    end
                end
            end
            CERR_BUS_ANSWER: begin
                state_d.bus = CERR_BUS_IDLE;
                // Control write commits at the edge that accepts it
                if (req.write && word_aligned && idx == CERR_IDX_CTRL) begin
                    if (req.byteenable[0]) begin
                        state_d.hold = req.writedata[CERR_CTRL_HOLD_BIT];
                    end
                    // Writing 1 to the blocked bit clears it
                    if (req.byteenable[1] && req.writedata[CERR_STAT_BLOCKED_BIT]) begin
                        state_d.blocked = 1'b0;
                    end
                end
            end
            default: begin
                state_d.bus = CERR_BUS_IDLE;
            end
        endcase
        // Dropped completion while frozen; set wins over clear
        if (meas_done_i && state_q.hold) begin
            state_d.blocked = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (state_q.bus != CERR_BUS_ANSWER);
    assign avs_readdata_o = state_q.rdata;
    assign avs_response_o = state_q.resp;
    assign results_valid_o = store_valid;

endmodule : cerr_result_bank

// ==== tb/cerr_result_bank_asserts.sv ====
// Concurrent checks on the echo result bank ports.
// Assumes it is bound to cerr_result_bank; shadows the engine results itself.
`timescale 1ns/1ns
module cerr_asserts
    import cerr_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Bus
    input wire logic [CERR_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [CERR_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [CERR_DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    // Engine and status
    input wire logic meas_done_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chc_fifth_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_first_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_second_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_third_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_fourth_i,
    input wire logic [CERR_LOC_W-1:0] echo_distance_chd_fifth_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_first_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_second_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_third_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_fourth_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_cha_fifth_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_chb_first_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_chb_second_i,
    input wire logic [CERR_AMP_W-1:0] echo_strength_chb_third_i,
    input wire logic results_valid_o
);
    typedef struct packed {logic [6:0][15:0] w; logic hold; logic blk;} cerr_chk_t;
    cerr_chk_t q, n;
    logic wr_ctrl;
    assign wr_ctrl = avs_write_i && !avs_waitrequest_o && avs_address_i == 11'h700;
    always_comb begin
        n = q;
        if (wr_ctrl && avs_byteenable_i[0])
            n.hold = avs_writedata_i[0];
        if (wr_ctrl && avs_byteenable_i[1] && avs_writedata_i[9])
            n.blk = 1'b0;
        if (meas_done_i && q.hold)
            n.blk = 1'b1;
        if (meas_done_i && !q.hold) begin
            n.w[0] = {echo_distance_chd_first_i, echo_distance_chc_fifth_i};
            n.w[1] = {echo_distance_chd_third_i, echo_distance_chd_second_i};
            n.w[2] = {echo_distance_chd_fifth_i, echo_distance_chd_fourth_i};
            n.w[3] = {1'b0, echo_strength_cha_second_i, 1'b0, echo_strength_cha_first_i};
            n.w[4] = {1'b0, echo_strength_cha_fourth_i, 1'b0, echo_strength_cha_third_i};
            n.w[5] = {1'b0, echo_strength_chb_first_i, 1'b0, echo_strength_cha_fifth_i};
            n.w[6] = {1'b0, echo_strength_chb_third_i, 1'b0, echo_strength_chb_second_i};
        end
        if (srst_i)
            n = '0;
    end
    always_ff @(posedge clock_i) begin
        q <= n;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    property p_word(logic [10:0] a, logic [15:0] w);
        avs_read_i && !avs_waitrequest_o && avs_address_i == a |->
            avs_readdata_o == {16'h0000, $past(w)};
    endproperty
    a_reset_clear: assert property (disable iff (1'b0) srst_i |=> avs_readdata_o == 32'h0 && !results_valid_o) else $error("not clear after reset");
    a_word_loc0: assert property (p_word(11'h65c, q.w[0])) else $error("word 0x0197 wrong");
    a_word_loc1: assert property (p_word(11'h660, q.w[1])) else $error("word 0x0198 wrong");
    a_word_loc2: assert property (p_word(11'h664, q.w[2])) else $error("word 0x0199 wrong");
    a_word_amp0: assert property (p_word(11'h668, q.w[3])) else $error("word 0x019a wrong");
    a_word_amp1: assert property (p_word(11'h66c, q.w[4])) else $error("word 0x019b wrong");
    a_word_amp2: assert property (p_word(11'h670, q.w[5])) else $error("word 0x019c wrong");
    a_word_amp3: assert property (p_word(11'h674, q.w[6])) else $error("word 0x019d wrong");
    a_one_wait: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait cycle count wrong");
    a_decode_error: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 11'h674 && avs_address_i != 11'h700 |-> avs_response_o == 2'h3 && avs_readdata_o == 32'h0) else $error("unmapped read wrong");
    a_valid_load: assert property (meas_done_i && !q.hold |-> ##1 results_valid_o) else $error("valid not raised");
    a_ctrl_word: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 11'h700 |-> avs_readdata_o == {22'h0, $past(q.blk), $past(results_valid_o), 7'h0, $past(q.hold)}) else $error("control word wrong");
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
    c_frozen: cover property (meas_done_i && q.hold);
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
    c_load: cover property (meas_done_i);
endmodule : cerr_asserts
bind cerr_result_bank cerr_asserts u_chk (.clock_i, .srst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .avs_response_o, .meas_done_i,
    .echo_distance_chc_fifth_i, .echo_distance_chd_first_i, .echo_distance_chd_second_i,
    .echo_distance_chd_third_i, .echo_distance_chd_fourth_i, .echo_distance_chd_fifth_i,
    .echo_strength_cha_first_i, .echo_strength_cha_second_i, .echo_strength_cha_third_i,
    .echo_strength_cha_fourth_i, .echo_strength_cha_fifth_i, .echo_strength_chb_first_i,
    .echo_strength_chb_second_i, .echo_strength_chb_third_i, .results_valid_o);

// ==== tb/tb.sv ====
// Self-checking bench for the echo result bank.
// Assumes the checker binds itself to the bank.
`timescale 1ns/1ns
module tb
    import cerr_pkg::*;
;
    logic clock_i = 0, srst_i = 1, rd = 0, wr = 0, done = 0, wreq, valid;
    logic [10:0] addr = 0;
    logic [31:0] wdata = 0, rdat, rdata;
    logic [1:0] rsp, resp;
    logic [7:0] loc [6] = '{default: 8'h00};
    logic [6:0] amp [8] = '{default: 7'h00};
    logic [7:0] eloc [6] = '{default: 8'h00};
    logic [6:0] eamp [8] = '{default: 7'h00};
    int err_count = 0, tests_run = 0, cyc = 0;
    always #25 clock_i = ~clock_i;
    cerr_result_bank DUT (.clock_i(clock_i), .srst_i(srst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .avs_response_o(rsp),
        .meas_done_i(done), .echo_distance_chc_fifth_i(loc[0]),
        .echo_distance_chd_first_i(loc[1]), .echo_distance_chd_second_i(loc[2]),
        .echo_distance_chd_third_i(loc[3]), .echo_distance_chd_fourth_i(loc[4]),
        .echo_distance_chd_fifth_i(loc[5]), .echo_strength_cha_first_i(amp[0]),
        .echo_strength_cha_second_i(amp[1]), .echo_strength_cha_third_i(amp[2]),
        .echo_strength_cha_fourth_i(amp[3]), .echo_strength_cha_fifth_i(amp[4]),
        .echo_strength_chb_first_i(amp[5]), .echo_strength_chb_second_i(amp[6]),
        .echo_strength_chb_third_i(amp[7]), .results_valid_o(valid));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic summarize();
        $display("err_count=%0d tests_run=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Holds the request until waitrequest is seen low, then releases it
    task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d);
        @(posedge clock_i);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clock_i);
        end while (wreq !== 1'b0);
        rdata = rdat;
        resp = rsp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    function automatic logic [15:0] exp_word(input int i);
        if (i < 3)
            return {eloc[2*i+1], eloc[2*i]};
        return {1'b0, eamp[2*i-5], 1'b0, eamp[2*i-6]};
    endfunction : exp_word
    task automatic sweep(input logic poke);
        logic [10:0] a;
        for (int i = 0; i < 7; i++) begin
            a = {CERR_IDX_FIRST + 9'(i), 2'b00};
            if (poke)
                bus(1'b1, a, 32'hffff_ffff);
            bus(1'b0, a, 32'h0);
            check(rdata, {16'h0000, exp_word(i)});
            check(32'(resp), 32'(CERR_RESP_OK));
        end
    endtask : sweep
    task automatic load(input logic [7:0] base, input logic frozen);
        @(posedge clock_i);
        foreach (loc[k])
            loc[k] <= base + 8'(k * 37);
        foreach (amp[k])
            amp[k] <= 7'(base + 8'(k * 53));
        done <= 1'b1;
        @(posedge clock_i);
        done <= 1'b0;
        // Frozen bank keeps the previous set
        if (!frozen) begin
            foreach (loc[k])
                eloc[k] = loc[k];
            foreach (amp[k])
                eamp[k] = amp[k];
        end
        repeat (2) @(posedge clock_i);
        check(32'(valid), 32'h1);
    endtask : load
    // ****************************************************************
    // Sequence
    // ****************************************************************
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        check(32'(valid), 32'h0);
        sweep(1'b0);
        load(8'h5a, 1'b0);
        sweep(1'b1);
        bus(1'b0, 11'h678, 32'h0);
        check(rdata, 32'h0);
        check(32'(resp), 32'(CERR_RESP_DECERR));
        bus(1'b0, 11'h65d, 32'h0);
        check(rdata, 32'h0);
        check(32'(resp), 32'(CERR_RESP_DECERR));
        bus(1'b1, 11'h700, 32'h0000_0001);
        load(8'h33, 1'b1);
        sweep(1'b0);
        bus(1'b0, 11'h700, 32'h0);
        check(rdata, 32'h0000_0301);
        bus(1'b1, 11'h700, 32'h0000_0200);
        bus(1'b0, 11'h700, 32'h0);
        check(rdata, 32'h0000_0100);
        load(8'hff, 1'b0);
        sweep(1'b0);
        @(posedge clock_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        foreach (loc[k])
            loc[k] <= 8'h00;
        foreach (amp[k])
            amp[k] <= 7'h00;
        foreach (eloc[k])
            eloc[k] = 8'h00;
        foreach (eamp[k])
            eamp[k] = 7'h00;
        check(32'(valid), 32'h0);
        sweep(1'b0);
        summarize();
    end
endmodule : tb
